// File: tb/rwt_host_model.sv
// Serial-side partner: START strobes and supply state
`timescale 1ns/10ps
module rwt_host_model (
    input  wire logic sys_clk_i,
    output logic      start_det_o,
    output logic      on_battery_o
);
    initial begin
        start_det_o  = 1'b0;
        on_battery_o = 1'b0;
    end
    task pulse_start;
        @(posedge sys_clk_i);
        start_det_o <= 1'b1;
        @(posedge sys_clk_i);
        start_det_o <= 1'b0;
    endtask
    task set_battery(input logic b);
        @(posedge sys_clk_i);
        on_battery_o <= b;
    endtask
endmodule

// File: tb/rwt_timer_asserts.sv
// Concurrent checks on the watchdog timer ports
`timescale 1ns/10ps
module rwt_timer_chk
    import rwt_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        start_det_i,
    input wire logic        on_battery_i,
    input wire logic        timer_irq_n_o,
    input wire logic        timer_flag_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic acc;
    logic clr;
    logic mapped;
    assign acc    = psel_i && penable_i && pready_o;
    assign clr    = acc && pwrite_i && paddr_i == OFS_STATUS && pwdata_i[STAT_FLAG];
    assign mapped = paddr_i inside {OFS_CTRL, OFS_TARGET, OFS_SUBRELOAD, OFS_STATUS, OFS_COUNT};

    chk_ready_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
        else $error("ready not after one wait state");
    chk_ready_once: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_ready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access phase");
    chk_err_decode: assert property (acc |-> pslverr_o == !mapped)
        else $error("error response does not match decode");
    chk_err_rdata: assert property (acc && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("unmapped read data not zero");
    chk_irq_flag: assert property ($fell(timer_irq_n_o) |-> timer_flag_o)
        else $error("interrupt without flag");
    chk_flag_sticky: assert property (timer_flag_o && !clr |=> timer_flag_o)
        else $error("flag cleared without software");
    chk_clear_release: assert property (clr && !timer_irq_n_o |=> timer_irq_n_o)
        else $error("interrupt held after flag clear");
    chk_reset_idle: assert property (disable iff (1'b0) rst_i |=> timer_irq_n_o && !timer_flag_o && !pready_o)
        else $error("outputs not idle in reset");

    cover property ($fell(timer_irq_n_o));
    cover property (acc && pslverr_o);
    cover property (clr && timer_flag_o);
endmodule

bind rwt_timer rwt_timer_chk chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .start_det_i(start_det_i),
    .on_battery_i(on_battery_i), .timer_irq_n_o(timer_irq_n_o), .timer_flag_o(timer_flag_o));

// File: tb/rwt_timer_test.sv
// Self-checking bench for the watchdog / power-fail timer
`timescale 1ns/10ps
module rwt_timer_test;
    import rwt_pkg::*;
    localparam int P  = 20;
    localparam int PC = 30;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        start_det;
    logic        on_battery;
    logic        irq_n;
    logic        flag;
    logic [31:0] r;
    logic        e;
    int          n;
    int          w;
    int          errors = 0;
    int          comparisons = 0;
    int          cyc = 0;

    always #50 clk = ~clk;
    rwt_host_model host_u (.sys_clk_i(clk), .start_det_o(start_det), .on_battery_o(on_battery));
    rwt_timer #(.MID_CYC(P), .SLOW_CYC(40), .PULSE_CYC(PC)) dut_u (.sys_clk_i(clk), .rst_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .start_det_i(start_det),
        .on_battery_i(on_battery), .timer_irq_n_o(irq_n), .timer_flag_o(flag));

    task finish_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            finish_test;
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        k = 0;
        // Request holds until pready is sampled high at a rising edge
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        check("pready", pready, 1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task cfg(input logic [7:0] t, input logic [7:0] rl, input logic [31:0] c);
        apb(1, OFS_CTRL, 0);
        apb(1, OFS_STATUS, 1);
        apb(1, OFS_TARGET, {24'h0, t});
        apb(1, OFS_SUBRELOAD, {24'h0, rl});
        apb(1, OFS_CTRL, c);
    endtask
    task wait_irq(input int lim);
        n = 0;
        @(negedge clk);
        while (irq_n !== 1'b0 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    task t_reset;
        logic [7:0]  ofs[5] = '{OFS_CTRL, OFS_TARGET, OFS_SUBRELOAD, OFS_STATUS, OFS_COUNT};
        logic [31:0] rv[5]  = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h100};
        apb(1, OFS_COUNT, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            apb(0, ofs[i], 0);
            check("reset value", r, rv[i]);
        end
        apb(0, 8'h14, 0);
        check("unmapped error", e, 1);
        check("unmapped data", r, 0);
    endtask
    task t_blocked;
        cfg(0, 1, 32'h0D);
        apb(0, OFS_STATUS, 0);
        check("blocked", r[STAT_BLOCKED], 1);
        apb(1, OFS_TARGET, 2);
        repeat (100) @(posedge clk);
        check("blocked idle", flag, 0);
        cfg(2, 1, 32'h0D);
        apb(0, OFS_STATUS, 0);
        check("unblocked", r[STAT_BLOCKED], 0);
    endtask
    task t_watchdog;
        int rl;
        int ew;
        for (int i = 0; i < 2; i++) begin
            rl = i ? 3 : 1;
            ew = (rl * P < PC) ? rl * P : PC;
            cfg(2, rl[7:0], 32'h0D);
            wait_irq(400);
            check("first interval", 32'(n >= 2 * rl * P - 4 && n <= 2 * rl * P + 8), 1);
            check("flag set", flag, 1);
            w = 0;
            while (irq_n === 1'b0 && w < 200) begin
                @(negedge clk);
                w++;
            end
            check("pulse width", 32'(w >= ew - 3 && w <= ew + 3), 1);
            wait_irq(400);
            check("periodic", irq_n, 0);
        end
        apb(1, OFS_CTRL, 0);
        apb(0, OFS_COUNT, 0);
        check("disabled count", r, 32'h100);
    endtask
    task t_start;
        cfg(2, 1, 32'h0D);
        repeat (8) begin
            repeat (24) @(posedge clk);
            host_u.pulse_start();
            check("restart", flag, 0);
        end
        wait_irq(80);
        check("idle expiry", irq_n, 0);
    endtask
    task t_sel_off;
        cfg(1, 1, 32'h09);
        repeat (150) @(posedge clk);
        check("select off", flag, 0);
        host_u.set_battery(1);
        cfg(1, 1, 32'h29);
        repeat (150) @(posedge clk);
        check("pf select off", flag, 0);
        host_u.set_battery(0);
    endtask
    task t_powerfail;
        logic [7:0] m1;
        cfg(1, 1, 32'h2D);
        apb(0, OFS_COUNT, 0);
        check("pf idle", r[7:0], 0);
        host_u.set_battery(1);
        repeat (2000) @(posedge clk);
        host_u.set_battery(0);
        apb(0, OFS_COUNT, 0);
        m1 = r[7:0];
        check("pf counting", 32'(m1 > 50 && m1 < 200), 1);
        repeat (200) @(posedge clk);
        apb(0, OFS_COUNT, 0);
        check("pf held", r[7:0], m1);
        host_u.set_battery(1);
        wait_irq(6000);
        check("pf resume", 32'(n >= (255 - m1) * P - 30 && n <= (255 - m1) * P + 30), 1);
        check("pf flag", flag, 1);
        repeat (100) @(posedge clk);
        apb(0, OFS_COUNT, 0);
        check("pf stopped", r[7:0], 8'hFF);
        check("pf irq held", irq_n, 0);
        apb(1, OFS_STATUS, 1);
        @(negedge clk);
        check("pf release", irq_n, 1);
        check("pf flag clear", flag, 0);
        apb(1, OFS_CTRL, 0);
        apb(0, OFS_COUNT, 0);
        check("pf cleared", r, 32'h100);
        host_u.set_battery(0);
    endtask

    initial begin
        clk     = 1'b0;
        rst     = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (8) @(posedge clk);
        rst <= 0;
        t_reset();
        t_blocked();
        t_watchdog();
        t_start();
        t_sel_off();
        t_powerfail();
        finish_test;
    end
endmodule

// File: verilog/rwt_pkg.sv
// Shared constants and types for the watchdog / power-fail timer
package rwt_pkg;

    // System clock
    localparam int CLK_PERIOD_NS = 100;

    // Timer clock periods and interrupt pulse cap
    localparam int TCLK_FAST_PERIOD_US = 244;
    localparam int TCLK_MID_PERIOD_MS  = 10;
    localparam int TCLK_SLOW_PERIOD_MS = 1000;
    localparam int IRQ_PULSE_MAX_MS    = 210;

    // Cycle counts derived from the periods
    localparam int FAST_CYC       = TCLK_FAST_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int MID_CYC_DFLT   = TCLK_MID_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SLOW_CYC_DFLT  = TCLK_SLOW_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PULSE_CYC_DFLT = IRQ_PULSE_MAX_MS * 1000000 / CLK_PERIOD_NS;

    localparam int DIV_W = 24;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_TARGET    = 8'h04;
    localparam logic [7:0] OFS_SUBRELOAD = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0C;
    localparam logic [7:0] OFS_COUNT     = 8'h10;

    // Control register fields
    localparam int CTRL_EN       = 0;
    localparam int CTRL_SEL_LO   = 1;
    localparam int CTRL_SEL_HI   = 2;
    localparam int CTRL_ROUTE    = 3;
    localparam int CTRL_PERIODIC = 4;
    localparam int CTRL_MODE_PF  = 5;

    // Status register fields
    localparam int STAT_FLAG    = 0;
    localparam int STAT_BATT    = 1;
    localparam int STAT_BLOCKED = 2;

    // Count register fields
    localparam int CNT_MAIN_LO = 0;
    localparam int CNT_MAIN_HI = 7;
    localparam int CNT_SUB_LO  = 8;
    localparam int CNT_SUB_HI  = 23;

    // Timer clock select codes
    localparam logic [1:0] TSEL_OFF  = 2'h0;
    localparam logic [1:0] TSEL_FAST = 2'h1;
    localparam logic [1:0] TSEL_MID  = 2'h2;
    localparam logic [1:0] TSEL_SLOW = 2'h3;

    // Reset and default values
    localparam logic [7:0]  TARGET_RST    = 8'h00;
    localparam logic [7:0]  SUBRELOAD_RST = 8'h00;
    localparam logic [7:0]  MAIN_DFLT     = 8'h00;
    localparam logic [7:0]  MAIN_START    = 8'h01;
    localparam logic [7:0]  PF_MAX        = 8'hFF;
    localparam logic [15:0] SUB_DFLT      = 16'h0001;
    localparam logic [15:0] SUB_START     = 16'h0001;

    // Default sub-timer reloads, used when the reload register is zero
    localparam logic [15:0] SUBDEF_FAST = 16'h035C;
    localparam logic [15:0] SUBDEF_MID  = 16'h0015;
    localparam logic [15:0] SUBDEF_SLOW = 16'h0001;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_STOP,
        ST_BLOCK
    } rwt_state_e;

endpackage

// File: verilog/rwt_tick.sv
// Timer clock divider: one-cycle tick at the selected timer clock rate
`timescale 1ns/10ps
module rwt_tick
    import rwt_pkg::*;
#(
    parameter int MID_CYC  = MID_CYC_DFLT,
    parameter int SLOW_CYC = SLOW_CYC_DFLT
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] sel_i,
    input  wire logic       run_i,
    output logic            tick_o
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } rwt_tick_s;

    rwt_tick_s s_r;
    rwt_tick_s s_nxt;

    function automatic logic [DIV_W-1:0] last_count(input logic [1:0] sel);
        unique case (sel)
            TSEL_FAST: last_count = DIV_W'(FAST_CYC - 1);
            TSEL_MID:  last_count = DIV_W'(MID_CYC - 1);
            TSEL_SLOW: last_count = DIV_W'(SLOW_CYC - 1);
            TSEL_OFF:  last_count = '0;
        endcase
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        // A zero select code never ticks, so the timer cannot run
        if (!run_i || sel_i == TSEL_OFF) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt >= last_count(sel_i)) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;

endmodule

// File: verilog/rwt_timer.sv
// Watchdog and power-fail timer with APB register access
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
module rwt_timer
    import rwt_pkg::*;
#(
    parameter int MID_CYC   = MID_CYC_DFLT,
    parameter int SLOW_CYC  = SLOW_CYC_DFLT,
    parameter int PULSE_CYC = PULSE_CYC_DFLT
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        start_det_i,
    input  wire logic        on_battery_i,
    output logic             timer_irq_n_o,
    output logic             timer_flag_o
);

    typedef struct packed {
        logic        ctrl_en;
        logic [1:0]  sel;
        logic        route;
        logic        periodic;
        logic        mode_pf;
        logic [7:0]  target;
        logic [7:0]  reload;
        logic        flag;
        rwt_state_e  st;
        logic [7:0]  main_cnt;
        logic [15:0] sub_cnt;
        logic        batt_q;
        logic        wd_hold;
        logic        pulse_on;
        logic [DIV_W-1:0] pulse_cnt;
        logic        irq_n;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rwt_state_s;

    rwt_state_s s_r;
    rwt_state_s s_nxt;

    logic tick;
    logic tick_run;

    // Address decode, shared by read and write paths
    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == OFS_CTRL) || (addr == OFS_TARGET) ||
                  (addr == OFS_SUBRELOAD) || (addr == OFS_STATUS) ||
                  (addr == OFS_COUNT);
    endfunction

    // Zero in the reload register selects the per-clock default
    function automatic logic [15:0] eff_reload(input logic [7:0]  rl,
                                               input logic [1:0]  sel);
        logic [15:0] dflt;
        unique case (sel)
            TSEL_FAST: dflt = SUBDEF_FAST;
            TSEL_MID:  dflt = SUBDEF_MID;
            TSEL_SLOW: dflt = SUBDEF_SLOW;
            TSEL_OFF:  dflt = SUBDEF_SLOW;
        endcase
        eff_reload = (rl == 8'h00) ? dflt : {8'h00, rl};
    endfunction

    // Sub-timer counts only in the running state and not during the pulse hold
    // A watchdog START also restarts the divider, so the fresh cycle is a full interval
    assign tick_run = (s_r.st == ST_RUN) &&
                      (s_r.mode_pf ? on_battery_i : (!s_r.wd_hold && !start_det_i));

    rwt_tick #(
        .MID_CYC  (MID_CYC),
        .SLOW_CYC (SLOW_CYC)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .sel_i     (s_r.sel),
        .run_i     (tick_run),
        .tick_o    (tick)
    );

    always_comb begin
        logic        acc;
        logic        wr;
        logic        flag_set;
        logic        flag_clr;
        logic        ovf;
        logic        new_en;
        logic        new_pf;
        logic [15:0] rl;

        s_nxt    = s_r;
        acc      = psel_i && penable_i && !s_r.pready;
        wr       = psel_i && penable_i && s_r.pready && pwrite_i && reg_hit(paddr_i);
        flag_set = 1'b0;
        flag_clr = wr && (paddr_i == OFS_STATUS) && pwdata_i[STAT_FLAG];
        ovf      = 1'b0;
        new_en   = pwdata_i[CTRL_EN];
        new_pf   = pwdata_i[CTRL_MODE_PF];
        rl       = eff_reload(s_r.reload, s_r.sel);

        s_nxt.batt_q  = on_battery_i;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;

        // APB access phase: answer one cycle after the first access cycle
        if (acc) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !reg_hit(paddr_i);
            s_nxt.prdata  = '0;
            if (!pwrite_i) begin
                unique case (paddr_i)
                    OFS_CTRL: begin
                        s_nxt.prdata[CTRL_EN]                 = s_r.ctrl_en;
                        s_nxt.prdata[CTRL_SEL_HI:CTRL_SEL_LO] = s_r.sel;
                        s_nxt.prdata[CTRL_ROUTE]              = s_r.route;
                        s_nxt.prdata[CTRL_PERIODIC]           = s_r.periodic;
                        s_nxt.prdata[CTRL_MODE_PF]            = s_r.mode_pf;
                    end
                    OFS_TARGET:    s_nxt.prdata[7:0] = s_r.target;
                    OFS_SUBRELOAD: s_nxt.prdata[7:0] = s_r.reload;
                    OFS_STATUS: begin
                        s_nxt.prdata[STAT_FLAG]    = s_r.flag;
                        s_nxt.prdata[STAT_BATT]    = s_r.batt_q;
                        s_nxt.prdata[STAT_BLOCKED] = (s_r.st == ST_BLOCK);
                    end
                    OFS_COUNT: begin
                        s_nxt.prdata[CNT_MAIN_HI:CNT_MAIN_LO] = s_r.main_cnt;
                        s_nxt.prdata[CNT_SUB_HI:CNT_SUB_LO]   = s_r.sub_cnt;
                    end
                    default: s_nxt.prdata = '0;
                endcase
            end
        end

        // Sub-timer step on each timer clock tick
        if (tick && tick_run) begin
            if (s_r.sub_cnt >= rl) begin
                s_nxt.sub_cnt = SUB_START;
                ovf = 1'b1;
            end else begin
                s_nxt.sub_cnt = s_r.sub_cnt + 16'h0001;
            end
        end

        unique case (s_r.st)
            ST_OFF, ST_BLOCK: begin
            end
            ST_RUN: begin
                if (s_r.mode_pf) begin
                    // Fresh start on battery entry from the idle count, otherwise resume the held count
                    if (on_battery_i && !s_r.batt_q && s_r.main_cnt == MAIN_DFLT) begin
                        s_nxt.main_cnt = MAIN_START;
                        s_nxt.sub_cnt  = SUB_START;
                    end else if (ovf) begin
                        s_nxt.main_cnt = s_r.main_cnt + 8'h01;
                        if (s_r.main_cnt == PF_MAX - 8'h01) begin
                            flag_set    = 1'b1;
                            s_nxt.irq_n = !s_r.route;
                            s_nxt.st    = ST_STOP;
                        end
                    end
                end else if (start_det_i) begin
                    s_nxt.main_cnt  = MAIN_START;
                    s_nxt.sub_cnt   = SUB_START;
                    s_nxt.wd_hold   = 1'b0;
                    s_nxt.pulse_on  = 1'b0;
                    s_nxt.pulse_cnt = '0;
                    s_nxt.irq_n     = 1'b1;
                end else begin
                    // Pulse window of the capped width, measured from expiry
                    if (s_r.pulse_on) begin
                        s_nxt.pulse_cnt = s_r.pulse_cnt + DIV_W'(1);
                        if (s_r.pulse_cnt >= DIV_W'(PULSE_CYC - 1)) begin
                            s_nxt.pulse_on = 1'b0;
                            s_nxt.wd_hold  = 1'b0;
                            s_nxt.irq_n    = 1'b1;
                        end
                    end
                    if (ovf) begin
                        // First overflow after expiry ends a short pulse and holds the count
                        if (s_r.pulse_on && s_nxt.pulse_on) begin
                            s_nxt.irq_n   = 1'b1;
                            s_nxt.wd_hold = 1'b1;
                        end
                        if (s_r.main_cnt >= s_r.target) begin
                            flag_set        = 1'b1;
                            s_nxt.main_cnt  = MAIN_START;
                            s_nxt.irq_n     = !s_r.route;
                            s_nxt.pulse_on  = 1'b1;
                            s_nxt.pulse_cnt = '0;
                            s_nxt.wd_hold   = 1'b0;
                        end else begin
                            s_nxt.main_cnt = s_r.main_cnt + 8'h01;
                        end
                    end
                end
            end
            ST_STOP: begin
                // Clearing the flag releases the pin and restarts the count
                if (flag_clr) begin
                    s_nxt.irq_n    = 1'b1;
                    s_nxt.main_cnt = MAIN_START;
                    s_nxt.sub_cnt  = SUB_START;
                    s_nxt.st       = ST_RUN;
                end
            end
        endcase

        // Set wins over a clear in the same cycle
        s_nxt.flag = flag_set || (s_r.flag && !flag_clr);

        // Register writes
        if (wr) begin
            unique case (paddr_i)
                OFS_CTRL: begin
                    s_nxt.ctrl_en  = new_en;
                    s_nxt.sel      = pwdata_i[CTRL_SEL_HI:CTRL_SEL_LO];
                    s_nxt.route    = pwdata_i[CTRL_ROUTE];
                    s_nxt.periodic = pwdata_i[CTRL_PERIODIC];
                    s_nxt.mode_pf  = new_pf;
                    if (!new_en) begin
                        s_nxt.st        = ST_OFF;
                        s_nxt.main_cnt  = MAIN_DFLT;
                        s_nxt.sub_cnt   = SUB_DFLT;
                        s_nxt.irq_n     = 1'b1;
                        s_nxt.pulse_on  = 1'b0;
                        s_nxt.pulse_cnt = '0;
                        s_nxt.wd_hold   = 1'b0;
                    end else if (!s_r.ctrl_en) begin
                        s_nxt.sub_cnt   = SUB_START;
                        s_nxt.irq_n     = 1'b1;
                        s_nxt.pulse_on  = 1'b0;
                        s_nxt.pulse_cnt = '0;
                        s_nxt.wd_hold   = 1'b0;
                        if (!new_pf && s_r.target == 8'h00) begin
                            s_nxt.st = ST_BLOCK;
                        end else if (!new_pf) begin
                            s_nxt.st       = ST_RUN;
                            s_nxt.main_cnt = MAIN_START;
                        end else begin
                            s_nxt.st       = ST_RUN;
                            s_nxt.main_cnt = on_battery_i ? MAIN_START : MAIN_DFLT;
                        end
                    end
                end
                OFS_TARGET:    s_nxt.target = pwdata_i[7:0];
                OFS_SUBRELOAD: s_nxt.reload = pwdata_i[7:0];
                OFS_STATUS, OFS_COUNT: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_r           <= '0;
            s_r.st        <= ST_OFF;
            s_r.target    <= TARGET_RST;
            s_r.reload    <= SUBRELOAD_RST;
            s_r.main_cnt  <= MAIN_DFLT;
            s_r.sub_cnt   <= SUB_DFLT;
            s_r.irq_n     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o      = s_r.prdata;
    assign pready_o      = s_r.pready;
    assign pslverr_o     = s_r.pslverr;
    assign timer_irq_n_o = s_r.irq_n;
    assign timer_flag_o  = s_r.flag;

endmodule
